// >>> sdc_ctrl_model.sv
// Controller model: differential clock, command pins and write data
`timescale 1ns/100ps
`default_nettype none

module sdc_ctrl_model (
   input  wire logic             i_clk,  // Bench clock
   output var  logic             o_ck,   // Clock, true
   output var  logic             o_ck_n, // Clock, complement
   output var  sdc_pkg::sdc_ca_t o_ca,   // Command pins
   output var  sdc_pkg::sdc_wd_t o_wd    // Write data pins
);
   import sdc_pkg::*;

   // CK stands still between commands; pins are only changed with CK low
   initial begin
      o_ck = 1'b0;
      o_ck_n = 1'b1;
      o_ca = 24'hF80000;
      o_wd = 19'h00000;
   end

   // One CK period: pins settle half a period before the rising crossing
   task automatic cmd(input logic cke, input logic [3:0] code, input logic [2:0] ba,
                      input logic [14:0] a, input logic odt);
      o_ca = {cke, code, ba, a, odt};
      repeat (4) @(posedge i_clk);
      #1;
      o_ck = 1'b1;
      o_ck_n = 1'b0;
      repeat (4) @(posedge i_clk);
      #1;
      o_ck = 1'b0;
      o_ck_n = 1'b1;
   endtask

   // Strobe edge centred in a data eye; lines are inverted once the hold ends
   task automatic wbeat(input logic [15:0] d, input logic ldm, input logic udm);
      o_wd.dq = d;
      o_wd.ldm = ldm;
      o_wd.udm = udm;
      repeat (3) @(posedge i_clk);
      #1;
      o_wd.ldqs = ~o_wd.ldqs;
      repeat (3) @(posedge i_clk);
      #1;
      o_wd.dq = ~d;
      // Let the inverted lines stand a cycle so the next beat never rewrites them at once
      @(posedge i_clk);
      #1;
   endtask

   // Self-refresh exit needs no clock edge
   task automatic set_cke(input logic v);
      o_ca.cke = v;
   endtask
endmodule // sdc_ctrl_model

`default_nettype wire

// >>> sdc_pkg.sv
// Package: constants, types and carriers of the x16 DDR3 command pin front end
// Notes on behaviour
// - Sample control/address at CK rise, CK# fall
// - Read strobes are referenced to CK crossings
// - ACT row, READ/WRITE column, A10 auto precharge
// - PRECHARGE: A10 low one bank, high all
// - OTF enabled: A12 high BL8, low BC4
// - Bank inputs select bank for ACT/RD/WR/PRE
// - LOAD MODE: bank inputs pick MR0-MR3, address op-code
// - Chip select high masks every command
// - Command from row, column, write strobes plus select
// - Clock enable low enters power-down or self refresh
// - Self-refresh exit on clock enable without clock
// - Power states switch off unused input buffers
// - Lower mask high discards lower data byte
// - Termination control drives data, strobe, mask termination
// - Termination control ignored when disabled by mode
// - Reset active low, asynchronous both ways
// - Upper mask high discards upper data byte
// - Read strobe edge-aligned with data; writes centred
package sdc_pkg;

   localparam int              ROW_W      = 15;
   localparam int              DQ_W       = 16;
   localparam int              BANKS      = 8;
   localparam int              MR_N       = 4;
   localparam int              A10_POS    = 10;
   localparam int              A12_POS    = 12;
   localparam int              MR0_BL_LSB = 0;
   localparam int              MR1_RTT0   = 2;
   localparam int              MR1_RTT1   = 6;
   localparam int              MR1_RTT2   = 9;
   localparam logic [1:0]      BL_FIX8    = 2'h0;
   localparam logic [1:0]      BL_OTF     = 2'h1;
   localparam logic [1:0]      BL_FIX4    = 2'h2;
   localparam logic [3:0]      BEATS_BL8  = 4'h8;
   localparam logic [3:0]      BEATS_BC4  = 4'h4;
   localparam logic [ROW_W-1:0] MR_RST    = 15'h0000;
   // Command codes as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0]      ENC_MRS    = 4'h0;
   localparam logic [3:0]      ENC_REF    = 4'h1;
   localparam logic [3:0]      ENC_PRE    = 4'h2;
   localparam logic [3:0]      ENC_ACT    = 4'h3;
   localparam logic [3:0]      ENC_WR     = 4'h4;
   localparam logic [3:0]      ENC_RD     = 4'h5;
   localparam logic [3:0]      ENC_ZQC    = 4'h6;

   typedef enum logic [3:0] {
      CMD_DES, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_ZQC
   } sdc_cmd_t;

   typedef enum logic [1:0] {PWR_ACT, PWR_PPD, PWR_APD, PWR_SREF} sdc_pwr_t;

   typedef struct packed {
      logic             cke;
      logic             cs_n;
      logic             ras_n;
      logic             cas_n;
      logic             we_n;
      logic [2:0]       ba;
      logic [ROW_W-1:0] a;
      logic             odt;
   } sdc_ca_t;

   typedef struct packed {
      logic            ldqs;
      logic            ldm;
      logic            udm;
      logic [DQ_W-1:0] dq;
   } sdc_wd_t;

   typedef struct packed {
      logic             valid;
      sdc_cmd_t         cmd;
      logic [2:0]       ba;
      logic [ROW_W-1:0] addr;
      logic             ap;
      logic             bc4;
   } sdc_req_t;

   typedef struct packed {
      logic            valid;
      logic [DQ_W-1:0] data;
      logic [1:0]      be;
   } sdc_wbeat_t;

   typedef struct packed {
      logic            oe;
      logic [DQ_W-1:0] dq;
      logic            ldqs;
      logic            ldqs_n;
      logic            udqs;
      logic            udqs_n;
   } sdc_rd_t;

   localparam sdc_rd_t    RD_IDLE  = '{oe: 1'b0, dq: 16'h0000, ldqs: 1'b0, ldqs_n: 1'b1,
                                       udqs: 1'b0, udqs_n: 1'b1};
   localparam sdc_req_t   REQ_IDLE = '{valid: 1'b0, cmd: CMD_NOP, ba: 3'h0,
                                       addr: 15'h0000, ap: 1'b0, bc4: 1'b0};
   localparam sdc_wbeat_t WB_IDLE  = '{valid: 1'b0, data: 16'h0000, be: 2'h0};

endpackage

// >>> sdc_top.sv
// Module: device-side command, address, power and data-pin front end of a x16 DDR3 part
`timescale 1ns/100ps
`default_nettype none

module sdc_top (
   input  wire logic                        I_CLK,       // 25 MHz block clock
   input  wire logic                        I_RESET,     // Block reset, active high
   input  wire logic                        I_RESET_N,   // Device reset pin, active low
   input  wire logic                        I_CK,        // Differential clock, true
   input  wire logic                        I_CK_N,      // Differential clock, complement
   input  wire sdc_pkg::sdc_ca_t            I_CA,        // Command/address/control pins
   input  wire sdc_pkg::sdc_wd_t            I_WD,        // Write data, masks, lower strobe
   input  wire logic [sdc_pkg::DQ_W-1:0]    I_RD_DATA,   // Read data from the array
   output var  sdc_pkg::sdc_req_t           O_CMD,       // Accepted command, one cycle
   output var  sdc_pkg::sdc_wbeat_t         O_WBEAT,     // Write beat with byte enables
   output var  sdc_pkg::sdc_rd_t            O_RD,        // Read data/strobe drive
   output var  logic                        O_RD_REQ,    // Read beat taken, pulse
   output var  logic                        O_ODT_ON,    // Termination on DQ/DQS/DM
   output var  logic [sdc_pkg::BANKS-1:0]   O_BANK_OPEN, // Row open per bank
   output var  sdc_pkg::sdc_pwr_t           O_PWR,       // Power state
   output var  logic                        O_CORE_EN,   // Internal clocks/circuitry on
   output var  logic                        O_CA_BUF_EN, // Command/address buffers on
   output var  logic                        O_CK_BUF_EN, // Clock and termination buffers on
   output var  logic                        O_BAD_CMD,   // Command to wrong bank state
   output var  logic [4*sdc_pkg::ROW_W-1:0] O_MR         // Mode registers 3..0
);
   import sdc_pkg::*;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic sdc_cmd_t decode(input logic [3:0] c);
      sdc_cmd_t r;
      r = CMD_NOP;
      case (c)
         ENC_MRS: r = CMD_MRS;
         ENC_REF: r = CMD_REF;
         ENC_PRE: r = CMD_PRE;
         ENC_ACT: r = CMD_ACT;
         ENC_WR:  r = CMD_WR;
         ENC_RD:  r = CMD_RD;
         ENC_ZQC: r = CMD_ZQC;
         default: r = c[3] ? CMD_DES : CMD_NOP;
      endcase
      return r;
   endfunction

   function automatic logic [BANKS-1:0] bank_hot(input logic [2:0] ba);
      return 8'h01 << ba;
   endfunction

   // ------------------------------------------------------------
   // Reset and synchronisers
   // ------------------------------------------------------------
   // The pin reset joins the block reset without a clock, so it takes
   // effect and lets go even while the link clock stands still.
   wire logic arst = I_RESET | ~I_RESET_N;

   sdc_ca_t    ca_s1_r;
   sdc_ca_t    ca_s2_r;
   sdc_wd_t    wd_s1_r;
   sdc_wd_t    wd_s2_r;
   logic [1:0] ck_s1_r;
   logic [1:0] ck_s2_r;
   logic       xing_prev_r;
   logic       ldqs_prev_r;

   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         ca_s1_r <= '0;
         ca_s2_r <= '0;
      end else begin
         ca_s1_r <= I_CA;
         ca_s2_r <= ca_s1_r;
      end
   end

   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         wd_s1_r <= '0;
         wd_s2_r <= '0;
      end else begin
         wd_s1_r <= I_WD;
         wd_s2_r <= wd_s1_r;
      end
   end

   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         ck_s1_r     <= 2'h1;
         ck_s2_r     <= 2'h1;
         xing_prev_r <= 1'b0;
         ldqs_prev_r <= 1'b0;
      end else begin
         ck_s1_r     <= {I_CK, I_CK_N};
         ck_s2_r     <= ck_s1_r;
         xing_prev_r <= ck_s2_r[1] & ~ck_s2_r[0];
         ldqs_prev_r <= wd_s2_r.ldqs;
      end
   end

   // ------------------------------------------------------------
   // Clock crossing and command decode
   // ------------------------------------------------------------
   // Only a rising CK together with a falling CK# counts, so a
   // single-ended glitch on one leg does not clock in a command.
   wire logic     xing    = ck_s2_r[1] & ~ck_s2_r[0];
   wire logic     ck_rise = xing & ~xing_prev_r;
   wire logic     ck_fall = ~xing & xing_prev_r;
   wire logic     ck_edge = ck_rise | ck_fall;
   wire logic     cke     = ca_s2_r.cke;
   wire sdc_cmd_t cmd_w   = decode({ca_s2_r.cs_n, ca_s2_r.ras_n,
                                    ca_s2_r.cas_n, ca_s2_r.we_n});

   sdc_pwr_t           pwr_r;
   sdc_pwr_t           pwr_nxt;
   logic [BANKS-1:0]   open_r;
   logic [BANKS-1:0]   open_nxt;
   logic [ROW_W-1:0]   mr_r [MR_N];
   logic [3:0]         rd_left_r;
   logic [3:0]         rd_left_nxt;
   logic [3:0]         wr_left_r;
   logic [3:0]         wr_left_nxt;

   // Command buffers are only alive in the active state
   wire logic cmd_go = ck_rise & cke & (pwr_r == PWR_ACT)
                       & (cmd_w != CMD_DES) & (cmd_w != CMD_NOP);

   wire logic [BANKS-1:0] hot   = bank_hot(ca_s2_r.ba);
   wire logic             a10   = ca_s2_r.a[A10_POS];
   wire logic             a12   = ca_s2_r.a[A12_POS];
   wire logic             is_rw = (cmd_w == CMD_RD) | (cmd_w == CMD_WR);
   wire logic             any_open = |open_r;

   // ------------------------------------------------------------
   // Burst length selection
   // ------------------------------------------------------------
   wire logic [1:0] bl_mode = mr_r[0][MR0_BL_LSB +: 2];
   wire logic       bc4_w   = (bl_mode == BL_OTF) ? ~a12 : (bl_mode == BL_FIX4);
   wire logic [3:0] beats_w = bc4_w ? BEATS_BC4 : BEATS_BL8;

   // ------------------------------------------------------------
   // Power state
   // ------------------------------------------------------------
   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         PWR_ACT: begin
            if (ck_rise && !cke) begin
               if (ca_s2_r.cs_n == 1'b0 && cmd_w == CMD_REF) begin
                  pwr_nxt = PWR_SREF;
               end else if (any_open) begin
                  pwr_nxt = PWR_APD;
               end else begin
                  pwr_nxt = PWR_PPD;
               end
            end
         end
         PWR_PPD, PWR_APD: begin
            if (ck_rise && cke) begin
               pwr_nxt = PWR_ACT;
            end
         end
         PWR_SREF: begin
            // Exit needs no CK edge: the controller may stop the clock here
            if (cke) begin
               pwr_nxt = PWR_ACT;
            end
         end
         default: pwr_nxt = PWR_ACT;
      endcase
   end

   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         pwr_r <= PWR_ACT;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // ------------------------------------------------------------
   // Bank bookkeeping
   // ------------------------------------------------------------
   // Auto precharge closes the bank as the command is taken; the burst
   // itself is unaffected, so a read with A10 set still completes.
   always_comb begin
      open_nxt = open_r;
      if (cmd_go) begin
         case (cmd_w)
            CMD_ACT: open_nxt = open_r | hot;
            CMD_PRE: open_nxt = a10 ? '0 : (open_r & ~hot);
            CMD_RD, CMD_WR: open_nxt = a10 ? (open_r & ~hot) : open_r;
            default: open_nxt = open_r;
         endcase
      end
   end

   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         open_r <= '0;
      end else begin
         open_r <= open_nxt;
      end
   end

   // Activate to an open bank, or access to a closed one
   wire logic bad_w = cmd_go & (((cmd_w == CMD_ACT) & |(open_r & hot))
                                | (is_rw & ~|(open_r & hot)));

   // ------------------------------------------------------------
   // Mode registers
   // ------------------------------------------------------------
   // A load with the top bank bit set names no register and is dropped.
   wire logic mrs_go = cmd_go & (cmd_w == CMD_MRS) & ~ca_s2_r.ba[2];

   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         for (int i = 0; i < MR_N; i++) begin
            mr_r[i] <= MR_RST;
         end
      end else if (mrs_go) begin
         mr_r[ca_s2_r.ba[1:0]] <= ca_s2_r.a;
      end
   end

   // ------------------------------------------------------------
   // Termination control
   // ------------------------------------------------------------
   wire logic rtt_en  = mr_r[1][MR1_RTT0] | mr_r[1][MR1_RTT1] | mr_r[1][MR1_RTT2];
   wire logic odt_nxt = ca_s2_r.odt & rtt_en & (pwr_r != PWR_SREF);

   // ------------------------------------------------------------
   // Burst counters
   // ------------------------------------------------------------
   wire logic rd_beat = (rd_left_r != 4'h0) & ck_edge;
   wire logic wr_beat = (wr_left_r != 4'h0) & (wd_s2_r.ldqs ^ ldqs_prev_r);

   assign rd_left_nxt = (cmd_go && cmd_w == CMD_RD) ? beats_w :
                        rd_beat ? rd_left_r - 4'h1 : rd_left_r;
   assign wr_left_nxt = (cmd_go && cmd_w == CMD_WR) ? beats_w :
                        wr_beat ? wr_left_r - 4'h1 : wr_left_r;

   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         rd_left_r <= 4'h0;
         wr_left_r <= 4'h0;
      end else begin
         rd_left_r <= rd_left_nxt;
         wr_left_r <= wr_left_nxt;
      end
   end

   // ------------------------------------------------------------
   // Read drive
   // ------------------------------------------------------------
   // Strobe follows the CK level at each crossing, so every data change after
   // the first beat of a burst lands on a strobe edge; the core must hold the next word ready.
   sdc_rd_t rd_nxt;

   always_comb begin
      rd_nxt = O_RD;
      if (rd_beat) begin
         rd_nxt.oe     = 1'b1;
         rd_nxt.dq     = I_RD_DATA;
         rd_nxt.ldqs   = ck_rise;
         rd_nxt.ldqs_n = ~ck_rise;
         rd_nxt.udqs   = ck_rise;
         rd_nxt.udqs_n = ~ck_rise;
      end else if (ck_edge) begin
         rd_nxt = RD_IDLE;
      end
   end

   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         O_RD     <= RD_IDLE;
         O_RD_REQ <= 1'b0;
      end else begin
         O_RD     <= rd_nxt;
         O_RD_REQ <= rd_beat;
      end
   end

   // ------------------------------------------------------------
   // Write capture
   // ------------------------------------------------------------
   // Data and masks pass the same two stages as the strobe, so the
   // beat stays lined up with its own mask bits.
   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         O_WBEAT <= WB_IDLE;
      end else begin
         O_WBEAT.valid <= wr_beat;
         O_WBEAT.data  <= wd_s2_r.dq;
         O_WBEAT.be    <= {~wd_s2_r.udm, ~wd_s2_r.ldm};
      end
   end

   // ------------------------------------------------------------
   // Command and status outputs
   // ------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         O_CMD <= REQ_IDLE;
      end else begin
         O_CMD.valid <= cmd_go;
         O_CMD.cmd   <= cmd_w;
         O_CMD.ba    <= ca_s2_r.ba;
         O_CMD.addr  <= ca_s2_r.a;
         O_CMD.ap    <= a10 & is_rw;
         O_CMD.bc4   <= bc4_w & is_rw;
      end
   end

   always_ff @(posedge I_CLK or posedge arst) begin
      if (arst) begin
         O_ODT_ON    <= 1'b0;
         O_CORE_EN   <= 1'b1;
         O_CA_BUF_EN <= 1'b1;
         O_CK_BUF_EN <= 1'b1;
         O_BAD_CMD   <= 1'b0;
      end else begin
         if (ck_rise || pwr_r == PWR_SREF) begin
            O_ODT_ON <= odt_nxt;
         end
         O_CORE_EN   <= (pwr_nxt == PWR_ACT);
         O_CA_BUF_EN <= (pwr_nxt == PWR_ACT);
         O_CK_BUF_EN <= (pwr_nxt != PWR_SREF);
         O_BAD_CMD   <= bad_w;
      end
   end

   assign O_PWR       = pwr_r;
   assign O_BANK_OPEN = open_r;
   assign O_MR        = {mr_r[3], mr_r[2], mr_r[1], mr_r[0]};

endmodule // sdc_top

`default_nettype wire

// >>> sdc_top_properties.sv
// Concurrent checks on the ports of the command pin front end
`timescale 1ns/100ps
`default_nettype none

module sdc_top_properties (
   input wire logic                        I_CLK,       // Clock
   input wire logic                        I_RESET,     // Reset
   input wire logic                        I_RESET_N,   // Pin reset
   input wire logic                        I_CK,        // CK
   input wire logic                        I_CK_N,      // CK#
   input wire sdc_pkg::sdc_ca_t            I_CA,        // Pins
   input wire sdc_pkg::sdc_wd_t            I_WD,        // Write pins
   input wire logic [sdc_pkg::DQ_W-1:0]    I_RD_DATA,   // Core data
   input wire sdc_pkg::sdc_req_t           O_CMD,       // Command
   input wire sdc_pkg::sdc_wbeat_t         O_WBEAT,     // Write beat
   input wire sdc_pkg::sdc_rd_t            O_RD,        // Read drive
   input wire logic                        O_RD_REQ,    // Read beat
   input wire logic                        O_ODT_ON,    // Termination
   input wire logic [sdc_pkg::BANKS-1:0]   O_BANK_OPEN, // Open banks
   input wire sdc_pkg::sdc_pwr_t           O_PWR,       // Power
   input wire logic                        O_CORE_EN,   // Core on
   input wire logic                        O_CA_BUF_EN, // CA buffers
   input wire logic                        O_CK_BUF_EN, // CK buffers
   input wire logic                        O_BAD_CMD,   // Bad command
   input wire logic [4*sdc_pkg::ROW_W-1:0] O_MR         // Mode registers
);
   import sdc_pkg::*;

   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RESET || !I_RESET_N);

   wire [3:0] code = {I_CA.cs_n, I_CA.ras_n, I_CA.cas_n, I_CA.we_n};
   wire       rw   = O_CMD.valid && (O_CMD.cmd == CMD_RD || O_CMD.cmd == CMD_WR);

   a_des_masked: assert property ($past(I_CA.cs_n, 2) |-> !O_CMD.valid)
      else $error("deselected command accepted");
   a_cmd_decode: assert property (O_CMD.valid |->
      (O_CMD.cmd == CMD_ACT) == ($past(code, 2) == ENC_ACT) &&
      (O_CMD.cmd == CMD_RD) == ($past(code, 2) == ENC_RD) &&
      (O_CMD.cmd == CMD_MRS) == ($past(code, 2) == ENC_MRS))
      else $error("command decoded wrongly");
   a_cmd_fields: assert property (O_CMD.valid |->
      O_CMD.ba == $past(I_CA.ba, 2) && O_CMD.addr == $past(I_CA.a, 2))
      else $error("bank or address not taken from pins");
   a_burst_chop: assert property (rw |-> O_CMD.ap == O_CMD.addr[A10_POS] &&
      O_CMD.bc4 == (O_MR[1:0] == BL_FIX4 || (O_MR[1:0] == BL_OTF && !O_CMD.addr[A12_POS])))
      else $error("auto precharge or chop wrong");
   a_pre_close: assert property (O_CMD.valid && O_CMD.cmd == CMD_PRE |->
      (O_CMD.addr[A10_POS] ? O_BANK_OPEN == 8'h00 : !O_BANK_OPEN[O_CMD.ba]))
      else $error("precharge closed wrong banks");
   a_mode_load: assert property (O_CMD.valid && O_CMD.cmd == CMD_MRS && !O_CMD.ba[2] |->
      O_MR[O_CMD.ba[1:0]*15 +: 15] == O_CMD.addr)
      else $error("mode register not loaded");
   a_pwr_enables: assert property (O_CORE_EN == (O_PWR == PWR_ACT) &&
      O_CA_BUF_EN == O_CORE_EN && O_CK_BUF_EN == (O_PWR != PWR_SREF))
      else $error("buffer enables disagree with power state");
   a_pd_entry: assert property (O_PWR == PWR_PPD && $past(O_PWR) == PWR_ACT |->
      !$past(I_CA.cke, 2) && $past(O_BANK_OPEN) == 8'h00)
      else $error("precharge power-down entered wrongly");
   a_wbeat_mask: assert property (O_WBEAT.valid |->
      O_WBEAT.be == ~{$past(I_WD.udm, 2), $past(I_WD.ldm, 2)} && O_WBEAT.data == $past(I_WD.dq, 2))
      else $error("write beat masks or data wrong");
   a_bad_cmd: assert property (O_CMD.valid |-> O_BAD_CMD ==
      (O_CMD.cmd == CMD_ACT ? |($past(O_BANK_OPEN) & (8'h01 << O_CMD.ba)) :
       rw && !(|($past(O_BANK_OPEN) & (8'h01 << O_CMD.ba)))))
      else $error("bank state flag wrong");
   a_reset_idle: assert property (disable iff (I_RESET) !I_RESET_N |->
      O_BANK_OPEN == 8'h00 && O_MR == 60'h0 && !O_CMD.valid && !O_RD.oe)
      else $error("pin reset did not clear state");
endmodule // sdc_top_properties

bind sdc_top sdc_top_properties i_props (.I_CLK(I_CLK), .I_RESET(I_RESET),
   .I_RESET_N(I_RESET_N), .I_CK(I_CK), .I_CK_N(I_CK_N), .I_CA(I_CA), .I_WD(I_WD),
   .I_RD_DATA(I_RD_DATA), .O_CMD(O_CMD), .O_WBEAT(O_WBEAT), .O_RD(O_RD), .O_RD_REQ(O_RD_REQ),
   .O_ODT_ON(O_ODT_ON), .O_BANK_OPEN(O_BANK_OPEN), .O_PWR(O_PWR), .O_CORE_EN(O_CORE_EN),
   .O_CA_BUF_EN(O_CA_BUF_EN), .O_CK_BUF_EN(O_CK_BUF_EN), .O_BAD_CMD(O_BAD_CMD), .O_MR(O_MR));

`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the command pin front end
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import sdc_pkg::*;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        rst_n = 1'b1;
   logic        ck, ck_n, rd_req, odt_on, core_en, ca_en, ck_en;
   sdc_ca_t     ca;
   sdc_wd_t     wd;
   sdc_req_t    cmd_o;
   sdc_wbeat_t  wb_o;
   sdc_rd_t     rd_o;
   sdc_pwr_t    pwr;
   logic [7:0]  banks;
   logic [59:0] mr;
   logic [15:0] rd_word = 16'h5AC3;
   logic [17:0] wq[$];
   int          failures = 0;
   int          n_checks = 0;
   int          beats, good_beats;

   sdc_top i_sdc_top (.I_CLK(clk), .I_RESET(rst), .I_RESET_N(rst_n), .I_CK(ck), .I_CK_N(ck_n),
      .I_CA(ca), .I_WD(wd), .I_RD_DATA(rd_word), .O_CMD(cmd_o), .O_WBEAT(wb_o), .O_RD(rd_o),
      .O_RD_REQ(rd_req), .O_ODT_ON(odt_on), .O_BANK_OPEN(banks), .O_PWR(pwr),
      .O_CORE_EN(core_en), .O_CA_BUF_EN(ca_en), .O_CK_BUF_EN(ck_en), .O_BAD_CMD(), .O_MR(mr));
   sdc_ctrl_model u_ctrl (.i_clk(clk), .o_ck(ck), .o_ck_n(ck_n), .o_ca(ca), .o_wd(wd));

   always #20 clk = ~clk;

   always @(posedge clk) begin
      if (rd_req === 1'b1) begin
         beats++;
         if (rd_o.oe === 1'b1 && rd_o.dq === rd_word && rd_o.ldqs === ~beats[0]
             && rd_o.ldqs_n === beats[0] && rd_o.udqs === ~beats[0]) good_beats++;
      end
      if (wb_o.valid === 1'b1) wq.push_back({wb_o.be, wb_o.data});
   end

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic w(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic c(input logic [3:0] code, input logic [2:0] ba, input logic [14:0] a);
      u_ctrl.cmd(1'b1, code, ba, a, 1'b0);
   endtask

   task automatic t_mode();
      c(ENC_MRS, 3'h0, 15'h0001);
      c(ENC_MRS, 3'h1, 15'h0004);
      c(ENC_MRS, 3'h4, 15'h7FFF);
      chk("mode regs", {30'h0, 15'h0004, 15'h0001}, mr);
      c(ENC_ACT | 4'h8, 3'h2, 15'h0000);
      c(4'h7, 3'h2, 15'h0000);
      chk("banks", 8'h00, banks);
      $display("test mode done");
   endtask

   task automatic t_bank();
      c(ENC_ACT, 3'h3, 15'h1234);
      c(ENC_ACT, 3'h5, 15'h0000);
      chk("banks", 8'h28, banks);
      c(ENC_PRE, 3'h3, 15'h0000);
      chk("banks", 8'h20, banks);
      c(ENC_PRE, 3'h0, 15'h0400);
      chk("banks", 8'h00, banks);
      $display("test bank done");
   endtask

   // A12 high leaves the bank open and reads eight beats on the fly, four under fixed BC4; low chops and auto precharges
   task automatic t_read(input logic a12, input int n);
      c(ENC_ACT, 3'h1, 15'h0000);
      beats = 0;
      good_beats = 0;
      c(ENC_RD, 3'h1, {2'h0, a12, 1'b0, ~a12, 10'h008});
      repeat (5) c(4'hF, 3'h0, 15'h0000);
      chk("read beats", n, beats);
      chk("read data", n, good_beats);
      chk("read idle", 1'b0, rd_o.oe);
      chk("banks", {6'h0, a12, 1'b0}, banks);
      $display("test read done");
   endtask

   // One strobe edge more than the burst: the spare one must be ignored
   task automatic t_write(input logic a12, input int n);
      wq.delete();
      c(ENC_ACT, 3'h2, 15'h0000);
      c(ENC_WR, 3'h2, {2'h0, a12, 12'h010});
      for (int i = 0; i <= n; i++) u_ctrl.wbeat(16'(16'h1357 * (i + 1)), i[0], i[1]);
      w(4);
      chk("write beats", n, wq.size());
      foreach (wq[i]) chk("write beat", {~i[1], ~i[0], 16'(16'h1357 * (i + 1))}, wq[i]);
      $display("test write done");
   endtask

   task automatic t_odt();
      u_ctrl.cmd(1'b1, 4'hF, 3'h0, 15'h0000, 1'b1);
      chk("termination", 1'b1, odt_on);
      u_ctrl.cmd(1'b1, 4'hF, 3'h0, 15'h0000, 1'b0);
      chk("termination", 1'b0, odt_on);
      c(ENC_MRS, 3'h1, 15'h0000);
      u_ctrl.cmd(1'b1, 4'hF, 3'h0, 15'h0000, 1'b1);
      chk("termination", 1'b0, odt_on);
      $display("test termination done");
   endtask

   task automatic t_power();
      c(ENC_PRE, 3'h0, 15'h0400);
      u_ctrl.cmd(1'b0, 4'hF, 3'h0, 15'h0000, 1'b0);
      chk("power", PWR_PPD, pwr);
      chk("enables", 3'b001, {core_en, ca_en, ck_en});
      u_ctrl.cmd(1'b0, ENC_ACT, 3'h4, 15'h0000, 1'b0);
      chk("banks", 8'h00, banks);
      c(4'hF, 3'h0, 15'h0000);
      chk("power", PWR_ACT, pwr);
      c(ENC_ACT, 3'h4, 15'h0000);
      u_ctrl.cmd(1'b0, 4'hF, 3'h0, 15'h0000, 1'b0);
      chk("power", PWR_APD, pwr);
      c(4'hF, 3'h0, 15'h0000);
      c(ENC_PRE, 3'h4, 15'h0000);
      u_ctrl.cmd(1'b0, ENC_REF, 3'h0, 15'h0000, 1'b0);
      chk("power", PWR_SREF, pwr);
      chk("enables", 3'b000, {core_en, ca_en, ck_en});
      u_ctrl.set_cke(1'b1);
      repeat (10) if (pwr !== PWR_ACT) w(1);
      chk("power", PWR_ACT, pwr);
      $display("test power done");
   endtask

   // Reset pin pulled low between clock edges must clear state at once
   task automatic t_rstn();
      c(ENC_ACT, 3'h6, 15'h0000);
      rst_n = 1'b0;
      #10;
      chk("banks", 8'h00, banks);
      w(1);
      rst_n = 1'b1;
      w(3);
      chk("mode regs", 60'h0, mr);
      $display("test pin reset done");
   endtask

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      w(6);
      rst = 1'b0;
      w(3);
      chk("power", PWR_ACT, pwr);
      chk("banks", 8'h00, banks);
      t_mode();
      t_bank();
      t_read(1'b0, 4);
      t_read(1'b1, 8);
      c(ENC_MRS, 3'h0, 15'h0002);
      t_read(1'b1, 4);
      c(ENC_MRS, 3'h0, 15'h0001);
      t_write(1'b0, 4);
      t_write(1'b1, 8);
      t_odt();
      t_power();
      t_rstn();
      end_of_test();
   end

   // About 21 us of traffic is expected
   initial begin
      #200000;
      failures++;
      $display("unexpected watchdog: expected end of tests, seen timeout");
      end_of_test();
   end
endmodule // testbench

`default_nettype wire
